// ===== src/nfhp_pkg.sv
package nfhp_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 25;
    localparam int STROBE_LOW_NS    = 40;
    localparam int STROBE_HIGH_NS   = 40;
    localparam int STROBE_LOW_CYC   = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_HIGH_CYC  = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int WB_NS            = 100;
    localparam int WB_CYC           = (WB_NS * CLK_MHZ + 999) / 1000;
    localparam int PAGE_LOAD_TIME_US = 25;
    localparam int PAGE_LOAD_CYC    = PAGE_LOAD_TIME_US * CLK_MHZ;
    localparam int RESET_ERASE_US   = 500;
    localparam int RESET_ERASE_CYC  = RESET_ERASE_US * CLK_MHZ;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int PAGE_BYTES       = 528;
    localparam int MAIN_BYTES       = 512;
    localparam int SPARE_BYTES      = 16;
    localparam int PAGES_PER_BLOCK  = 32;
    localparam int BLOCKS           = 4096;
    localparam int ADDR_CYCLES      = 4;
    localparam int MAX_PROGRAMS     = 3;
    // ------------------------------------------------------------
    // commands
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_LO   = 8'h00;
    localparam logic [7:0] CMD_READ_HI   = 8'h01;
    localparam logic [7:0] CMD_READ_SP   = 8'h50;
    localparam logic [7:0] CMD_DATA_IN   = 8'h80;
    localparam logic [7:0] CMD_PROGRAM   = 8'h10;
    localparam logic [7:0] CMD_ERASE_SET = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO  = 8'hd0;
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] CMD_RESET     = 8'hff;
    // ------------------------------------------------------------
    // status byte fields
    // ------------------------------------------------------------
    localparam int ST_FAIL_BIT  = 0;
    localparam int ST_READY_BIT = 6;
    localparam int ST_NOWP_BIT  = 7;
    // ------------------------------------------------------------
    // user-side operation codes and internal bus cycle kinds
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        NFHP_OP_READ,
        NFHP_OP_PROGRAM,
        NFHP_OP_ERASE,
        NFHP_OP_STATUS,
        NFHP_OP_RESET
    } nfhp_op_t;
    typedef enum logic [1:0] {
        NFHP_CYC_CMD,
        NFHP_CYC_ADDR,
        NFHP_CYC_DIN,
        NFHP_CYC_DOUT
    } nfhp_cyc_t;
endpackage

// ===== src/nfhp_cyc_if.sv
interface nfhp_cyc_if;
    import nfhp_pkg::*;
    logic       start;
    nfhp_cyc_t  kind;
    logic [7:0] wdata;
    logic       done;
    logic [7:0] rdata;
    modport seq (output start, output kind, output wdata, input done, input rdata);
    modport pin (input start, input kind, input wdata, output done, output rdata);
endinterface

// ===== src/nfhp_pin_cycle.sv
module nfhp_pin_cycle
    import nfhp_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    nfhp_cyc_if.pin         cyc,
    input  wire logic [7:0] byte_port_in_i,
    output logic [7:0]      byte_port_out_o,
    output logic            byte_port_oe_n_o,
    output logic            cmd_latch_o,
    output logic            addr_latch_o,
    output logic            write_strobe_n_o,
    output logic            read_strobe_n_o
);
    // ------------------------------------------------------------
    // one bus cycle: strobe low phase, then high phase
    // ------------------------------------------------------------
    typedef enum logic [1:0] {PC_IDLE, PC_LOW, PC_HIGH} nfhp_pc_t;
    localparam int CW = 4;
    nfhp_pc_t        st_q, st_d;
    logic [CW-1:0]   cnt_q, cnt_d;
    nfhp_cyc_t       kind_q, kind_d;
    logic [7:0]      wd_q, wd_d, rd_q, rd_d;
    logic [7:0]      s1_q, s2_q, s3_q;

    // pin data comes from outside our clock: three stages, agree of last two
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            s3_q <= 8'h00;
        end else begin
            s1_q <= byte_port_in_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        kind_d = kind_q;
        wd_d   = wd_q;
        rd_d   = rd_q;
        cyc.done = 1'b0;
        unique case (st_q)
            PC_IDLE: begin
                if (cyc.start) begin
                    st_d   = PC_LOW;
                    kind_d = cyc.kind;
                    wd_d   = cyc.wdata;
                    cnt_d  = CW'(STROBE_LOW_CYC + 2);
                end
            end
            PC_LOW: begin
                if (cnt_q == '0) begin
                    // sample late in the low phase, after access time and sync delay
                    if (s2_q == s3_q) begin
                        rd_d = s3_q;
                    end
                    st_d  = PC_HIGH;
                    cnt_d = CW'(STROBE_HIGH_CYC);
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            PC_HIGH: begin
                if (cnt_q == '0) begin
                    st_d     = PC_IDLE;
                    cyc.done = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q   <= PC_IDLE;
            cnt_q  <= '0;
            kind_q <= NFHP_CYC_CMD;
            wd_q   <= 8'h00;
            rd_q   <= 8'h00;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            kind_q <= kind_d;
            wd_q   <= wd_d;
            rd_q   <= rd_d;
        end
    end

    wire active = (st_q != PC_IDLE);
    wire is_rd  = (kind_q == NFHP_CYC_DOUT);
    assign cyc.rdata        = rd_q;
    assign byte_port_out_o  = wd_q;
    // latches stay up across the whole write so the rising edge sees them
    assign cmd_latch_o      = active && kind_q == NFHP_CYC_CMD;
    assign addr_latch_o     = active && kind_q == NFHP_CYC_ADDR;
    assign write_strobe_n_o = !(st_q == PC_LOW && !is_rd);
    // falling edge of read strobe fetches the next byte
    assign read_strobe_n_o  = !(st_q == PC_LOW && is_rd);
    assign byte_port_oe_n_o = !(active && !is_rd);

    chk_read_no_drive : assert property (@(posedge clk_i) disable iff (rst_i)
        !read_strobe_n_o |-> byte_port_oe_n_o) else $error("host drives bus during read");
    chk_strobe_width : assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(write_strobe_n_o) |-> !write_strobe_n_o [*3]) else $error("write strobe too short");
endmodule

// ===== src/nfhp_host.sv
module nfhp_host
    import nfhp_pkg::*;
#(
    parameter int BUSY_TIMEOUT_CYC = RESET_ERASE_CYC * 20
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire nfhp_op_t    req_op_i,
    input  wire logic [1:0]  req_area_i,
    input  wire logic [25:0] req_addr_i,
    input  wire logic [9:0]  req_len_i,
    output logic             wr_ready_o,
    input  wire logic [7:0]  wr_data_i,
    output logic             rd_valid_o,
    output logic [7:0]       rd_data_o,
    output logic             done_o,
    output logic             fail_o,
    output logic             guard_block_o,
    input  wire logic        write_guard_en_i,
    output logic             chip_select_n_o,
    output logic             write_guard_n_o,
    output logic             cmd_latch_o,
    output logic             addr_latch_o,
    output logic             write_strobe_n_o,
    output logic             read_strobe_n_o,
    input  wire logic [7:0]  byte_port_in_i,
    output logic [7:0]       byte_port_out_o,
    output logic             byte_port_oe_n_o,
    input  wire logic        ready_busy_n_i
);
    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE, S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_WAITB, S_BUSY,
        S_STCMD, S_STRD, S_RDATA, S_DONE
    } nfhp_st_t;

    nfhp_cyc_if cyc ();
    nfhp_st_t       st_q, st_d;
    nfhp_op_t       op_q, op_d;
    logic [1:0]     area_q, area_d;
    logic [25:0]    addr_q, addr_d;
    logic [9:0]     len_q, len_d;
    logic [1:0]     acnt_q, acnt_d;
    logic [31:0]    tcnt_q, tcnt_d;
    logic           issued_q, issued_d;
    logic           fail_q, fail_d;
    logic [7:0]     rdat_q, rdat_d;
    logic           rdv_q, rdv_d;
    logic           done_q, done_d;
    logic           rb1_q, rb2_q, rb3_q, rb_q;

    nfhp_pin_cycle u_pin (
        .clk_i            (clk_i),
        .rst_i            (rst_i),
        .cyc              (cyc.pin),
        .byte_port_in_i   (byte_port_in_i),
        .byte_port_out_o  (byte_port_out_o),
        .byte_port_oe_n_o (byte_port_oe_n_o),
        .cmd_latch_o      (cmd_latch_o),
        .addr_latch_o     (addr_latch_o),
        .write_strobe_n_o (write_strobe_n_o),
        .read_strobe_n_o  (read_strobe_n_o)
    );

    // ready_busy_n is a pin: three stages, change taken when last two agree
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rb1_q <= 1'b1;
            rb2_q <= 1'b1;
            rb3_q <= 1'b1;
            rb_q  <= 1'b1;
        end else begin
            rb1_q <= ready_busy_n_i;
            rb2_q <= rb1_q;
            rb3_q <= rb2_q;
            if (rb2_q == rb3_q) begin
                rb_q <= rb3_q;
            end
        end
    end

    function automatic logic [7:0] read_cmd(input logic [1:0] area);
        return (area == 2'd2) ? CMD_READ_SP : (area == 2'd1) ? CMD_READ_HI : CMD_READ_LO;
    endfunction

    function automatic logic [7:0] addr_byte(input logic [25:0] a, input logic [1:0] i);
        // half page select bit is never sent; upper bits of the last byte are zero
        // rows map onto 32-page blocks of the 4096-block array
        unique case (i)
            2'd0:    return a[7:0];
            2'd1:    return a[16:9];
            2'd2:    return a[24:17];
            default: return {7'h00, a[25]};
        endcase
    endfunction

    wire blocked = !write_guard_en_i && (req_op_i == NFHP_OP_PROGRAM || req_op_i == NFHP_OP_ERASE);

    always_comb begin
        st_d = st_q; op_d = op_q; area_d = area_q; addr_d = addr_q; len_d = len_q;
        acnt_d = acnt_q; tcnt_d = tcnt_q; issued_d = 1'b0; fail_d = fail_q;
        rdat_d = rdat_q; rdv_d = 1'b0; done_d = 1'b0;
        cyc.start = 1'b0; cyc.kind = NFHP_CYC_CMD; cyc.wdata = 8'h00;
        wr_ready_o = 1'b0;
        unique case (st_q)
            S_IDLE: begin
                if (req_valid_i && !blocked) begin
                    op_d = req_op_i; area_d = req_area_i; addr_d = req_addr_i;
                    len_d = req_len_i; acnt_d = 2'd0; fail_d = 1'b0;
                    st_d = (req_op_i == NFHP_OP_STATUS) ? S_STCMD : S_CMD1;
                end
            end
            S_CMD1: begin
                cyc.start = !issued_q;
                unique case (op_q)
                    NFHP_OP_READ:    cyc.wdata = read_cmd(area_q);
                    NFHP_OP_PROGRAM: cyc.wdata = CMD_DATA_IN;
                    NFHP_OP_ERASE:   cyc.wdata = CMD_ERASE_SET;
                    default:         cyc.wdata = CMD_RESET;
                endcase
                issued_d = !cyc.done;
                if (cyc.done) begin
                    // erase sends only the three row bytes, starting at byte 1
                    acnt_d = (op_q == NFHP_OP_ERASE) ? 2'd1 : 2'd0;
                    st_d   = (op_q == NFHP_OP_RESET) ? S_WAITB : S_ADDR;
                    tcnt_d = WB_CYC;
                end
            end
            S_ADDR: begin
                cyc.start = !issued_q; cyc.kind = NFHP_CYC_ADDR;
                cyc.wdata = addr_byte(addr_q, acnt_q);
                issued_d = !cyc.done;
                if (cyc.done) begin
                    acnt_d = acnt_q + 2'd1;
                    if (acnt_q == 2'(ADDR_CYCLES - 1)) begin
                        tcnt_d = WB_CYC;
                        unique case (op_q)
                            NFHP_OP_PROGRAM: st_d = S_WDATA;
                            NFHP_OP_ERASE:   st_d = S_CMD2;
                            default:         st_d = S_WAITB;
                        endcase
                    end
                end
            end
            S_WDATA: begin
                // page length is the caller's; the device wraps past column 527
                // keeping to three programs per page before an erase is the caller's duty
                wr_ready_o = !issued_q && !cyc.start;
                cyc.start = !issued_q; cyc.kind = NFHP_CYC_DIN; cyc.wdata = wr_data_i;
                issued_d = !cyc.done;
                if (cyc.done) begin
                    len_d = len_q - 10'd1;
                    if (len_q <= 10'd1) st_d = S_CMD2;
                end
            end
            S_CMD2: begin
                cyc.start = !issued_q;
                cyc.wdata = (op_q == NFHP_OP_ERASE) ? CMD_ERASE_GO : CMD_PROGRAM;
                issued_d = !cyc.done;
                if (cyc.done) begin
                    st_d = S_WAITB; tcnt_d = WB_CYC;
                end
            end
            S_WAITB: begin
                // busy may take a while to appear at our sampler
                tcnt_d = tcnt_q - 32'd1;
                if (!rb_q || tcnt_q == 32'd0) begin
                    st_d = S_BUSY; tcnt_d = 32'(BUSY_TIMEOUT_CYC);
                end
            end
            S_BUSY: begin
                // no commands while the device is busy
                // timeout leaves margin over page load and reset recovery
                tcnt_d = tcnt_q - 32'd1;
                if (tcnt_q == 32'd0) begin
                    fail_d = 1'b1; st_d = S_DONE;
                end else if (rb_q) begin
                    unique case (op_q)
                        NFHP_OP_READ:  st_d = S_RDATA;
                        NFHP_OP_RESET: st_d = S_DONE;
                        default:       st_d = S_STCMD;
                    endcase
                end
            end
            S_STCMD: begin
                cyc.start = !issued_q; cyc.wdata = CMD_STATUS;
                issued_d = !cyc.done;
                if (cyc.done) st_d = S_STRD;
            end
            S_STRD: begin
                cyc.start = !issued_q; cyc.kind = NFHP_CYC_DOUT;
                issued_d = !cyc.done;
                if (cyc.done) begin
                    rdat_d = cyc.rdata; rdv_d = (op_q == NFHP_OP_STATUS);
                    // fail bit only counts when the ready bit is set
                    fail_d = cyc.rdata[ST_READY_BIT] && cyc.rdata[ST_FAIL_BIT];
                    st_d = S_DONE;
                end
            end
            S_RDATA: begin
                cyc.start = !issued_q; cyc.kind = NFHP_CYC_DOUT;
                issued_d = !cyc.done;
                if (cyc.done) begin
                    rdat_d = cyc.rdata; rdv_d = 1'b1; len_d = len_q - 10'd1;
                    if (len_q <= 10'd1) st_d = S_DONE;
                end
            end
            S_DONE: begin
                done_d = 1'b1; st_d = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= S_IDLE; op_q <= NFHP_OP_READ; area_q <= 2'd0; addr_q <= '0;
            len_q <= '0; acnt_q <= '0; tcnt_q <= '0; issued_q <= 1'b0;
            fail_q <= 1'b0; rdat_q <= 8'h00; rdv_q <= 1'b0; done_q <= 1'b0;
        end else begin
            st_q <= st_d; op_q <= op_d; area_q <= area_d; addr_q <= addr_d;
            len_q <= len_d; acnt_q <= acnt_d; tcnt_q <= tcnt_d; issued_q <= issued_d;
            fail_q <= fail_d; rdat_q <= rdat_d; rdv_q <= rdv_d; done_q <= done_d;
        end
    end

    assign req_ready_o     = (st_q == S_IDLE) && !blocked;
    assign guard_block_o   = req_valid_i && blocked && st_q == S_IDLE;
    assign rd_valid_o      = rdv_q;
    assign rd_data_o       = rdat_q;
    assign done_o          = done_q;
    assign fail_o          = fail_q;
    // release select when idle so the device may stand
    assign chip_select_n_o = (st_q == S_IDLE);
    // guard pin is active low: permission drives it high, refusal pulls it low
    assign write_guard_n_o = write_guard_en_i;

    chk_addr_four : assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(addr_latch_o) && acnt_q == 2'd0 |-> ##[1:40] (st_q == S_ADDR && acnt_q == 2'd1))
        else $error("address sequence stalled");
    chk_no_cmd_busy : assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == S_BUSY |-> write_strobe_n_o && read_strobe_n_o) else $error("command while busy");
    chk_guard_block : assert property (@(posedge clk_i) disable iff (rst_i)
        !write_guard_en_i |-> !(st_q == S_CMD2)) else $error("program while guarded");
    chk_fourth_byte : assert property (@(posedge clk_i) disable iff (rst_i)
        addr_latch_o && !write_strobe_n_o && acnt_q == 2'd3 |-> byte_port_out_o[7:1] == 7'h00)
        else $error("byte 4 high bits");
    chk_erase_pair : assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == S_CMD2 && op_q == NFHP_OP_ERASE && !write_strobe_n_o |-> byte_port_out_o == CMD_ERASE_GO)
        else $error("erase confirm");
    chk_prog_pair : assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == S_CMD2 && op_q == NFHP_OP_PROGRAM && !write_strobe_n_o |-> byte_port_out_o == CMD_PROGRAM)
        else $error("program confirm");
    chk_select_busy : assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == S_BUSY |-> !chip_select_n_o) else $error("select dropped while busy");
    chk_read_cmd : assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == S_CMD1 && op_q == NFHP_OP_READ && area_q == 2'd2 && !write_strobe_n_o
        |-> byte_port_out_o == CMD_READ_SP)
        else $error("spare read command");
endmodule

// ===== sim/nfhp_flash_model.sv
module nfhp_flash_model #(
    parameter int LOAD_NS  = 2000,
    parameter int PROG_NS  = 4000,
    parameter int ERASE_NS = 6000,
    parameter int RST_NS   = 400
) (
    input  wire logic       cs_n_i,
    input  wire logic       wg_n_i,
    input  wire logic       cmd_i,
    input  wire logic       adr_i,
    input  wire logic       wr_n_i,
    input  wire logic       rd_n_i,
    input  wire logic [7:0] dq_i,
    output logic [7:0]      dq_o,
    output logic            pull_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [int];
    logic [7:0]  wbuf [int];
    logic [16:0] row = 17'h0;
    logic        stat = 1'b0;
    logic        drv = 1'b0;
    int          col = 0, half = 3, nadr = 4, dur = 0, a;
    event        go;
    initial dq_o = 8'h00;
    initial pull_o = 1'b0;
    // deselected: every strobe is ignored
    always @(posedge wr_n_i) if (!cs_n_i) begin
        if (cmd_i) begin
            stat = (dq_i == 8'h70);
            case (dq_i)
                8'h00, 8'h01, 8'h50: begin half = dq_i[0] + 2 * dq_i[6]; nadr = 0; end
                8'h80: begin wbuf.delete(); half = 3; nadr = 0; end
                8'h60: begin half = 3; nadr = 1; end
                8'h10: begin
                    if (wg_n_i) foreach (wbuf[k]) mem[int'(row) * 528 + k] = wbuf[k];
                    dur = PROG_NS;
                    ->go;
                end
                8'hd0: begin
                    if (wg_n_i) for (int k = 0; k < 16896; k++) mem.delete(int'(row[16:5]) * 16896 + k);
                    dur = ERASE_NS;
                    ->go;
                end
                8'hff: begin dur = RST_NS; ->go; end
                default: ;
            endcase
        end else if (adr_i) begin
            case (nadr)
                0: col = dq_i;
                1: row[7:0] = dq_i;
                2: row[15:8] = dq_i;
                default: row[16] = dq_i[0];
            endcase
            nadr++;
            if (nadr == 4 && half < 3) begin
                col = (half == 2) ? 512 + col % 16 : col + 256 * half;
                dur = LOAD_NS;
                ->go;
            end
        end else begin
            wbuf[col] = dq_i;
            col++;
        end
    end
    always @(negedge rd_n_i) if (!cs_n_i) begin
        a = int'(row) * 528 + col;
        drv = 1'b1;
        dq_o = stat ? {wg_n_i, !pull_o, 6'h00} : (mem.exists(a) ? mem[a] : 8'hff);
        if (!stat) col++;
    end
    // a released port shows a changed value, never the last byte
    always @(posedge rd_n_i or posedge cs_n_i) if (drv) begin
        drv = 1'b0;
        dq_o = ~dq_o;
    end
    always @go begin
        #20 pull_o = 1'b1;
        #(dur) pull_o = 1'b0;
    end
endmodule

// ===== sim/nfhp_host_tb.sv
module nfhp_host_tb
    import nfhp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0, rst_i = 1, req_valid_i = 0, write_guard_en_i = 1;
    logic        req_ready_o, wr_ready_o, rd_valid_o, done_o, fail_o, guard_block_o, pull;
    logic        chip_select_n_o, write_guard_n_o, cmd_latch_o, addr_latch_o, write_strobe_n_o;
    logic        read_strobe_n_o, byte_port_oe_n_o, ready_busy_n_i;
    nfhp_op_t    req_op_i = NFHP_OP_STATUS;
    logic [1:0]  req_area_i = 2'h0;
    logic [25:0] req_addr_i = 26'h0;
    logic [9:0]  req_len_i = 10'h1;
    logic [7:0]  wr_data_i = 8'h00, rd_data_o, byte_port_out_o, byte_port_in_i, dev_out;
    logic [7:0]  ref_mem [int];
    logic [7:0]  wq [$];
    logic [7:0]  eq [$];
    int          seed = 45864, n_fail = 0, checked = 0, wi = 0;
    assign ready_busy_n_i = !pull;
    assign byte_port_in_i = !byte_port_oe_n_o ? byte_port_out_o : dev_out;
    always #20 clk_i = ~clk_i;
    nfhp_host #(.BUSY_TIMEOUT_CYC(2000)) u_nfhp_host (.clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_op_i,
        .req_area_i, .req_addr_i, .req_len_i, .wr_ready_o, .wr_data_i, .rd_valid_o, .rd_data_o, .done_o,
        .fail_o, .guard_block_o, .write_guard_en_i, .chip_select_n_o, .write_guard_n_o, .cmd_latch_o,
        .addr_latch_o, .write_strobe_n_o, .read_strobe_n_o, .byte_port_in_i, .byte_port_out_o,
        .byte_port_oe_n_o, .ready_busy_n_i);
    nfhp_flash_model u_nfhp_flash_model (.cs_n_i(chip_select_n_o), .wg_n_i(write_guard_n_o),
        .cmd_i(cmd_latch_o), .adr_i(addr_latch_o), .wr_n_i(write_strobe_n_o), .rd_n_i(read_strobe_n_o),
        .dq_i(byte_port_in_i), .dq_o(dev_out), .pull_o(pull));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic run(input nfhp_op_t op, input int area, input int row, input int col, input int len);
        int n;
        int b;
        b = row * 528 + col;
        wq.delete();
        for (int i = 0; i <= len; i++) wq.push_back(8'($random(seed)));
        if (op == NFHP_OP_PROGRAM) for (int i = 0; i < len; i++) ref_mem[b + i] = wq[i];
        if (op == NFHP_OP_ERASE) for (int k = 0; k < 16896; k++) ref_mem.delete(row / 32 * 16896 + k);
        if (op == NFHP_OP_READ) begin
            b = row * 528 + (area == 2 ? 512 + col % 16 : col + 256 * area);
            for (int i = 0; i < len; i++) eq.push_back(ref_mem.exists(b + i) ? ref_mem[b + i] : 8'hff);
        end
        if (op == NFHP_OP_STATUS) eq.push_back({write_guard_en_i, 7'h40});
        wi <= 0;
        wr_data_i <= wq[0];
        req_op_i <= op;
        req_area_i <= 2'(area);
        req_addr_i <= {17'(row), 1'b0, 8'(col)};
        req_len_i <= 10'(len);
        req_valid_i <= 1'b1;
        n = 0;
        do begin @(negedge clk_i); n++; end while (req_ready_o !== 1'b1 && n < 100);
        if (req_ready_o !== 1'b1) begin n_fail++; give_verdict(); end
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        do begin @(negedge clk_i); n++; end while (done_o !== 1'b1 && n < 30000);
        if (n >= 30000) begin n_fail++; give_verdict(); end
        chk("bytes_left", 8'(eq.size()), 8'h00);
        chk("fail", {7'h0, fail_o}, 8'h00);
        @(posedge clk_i);
    endtask
    always @(posedge clk_i) if (wr_ready_o === 1'b1) begin
        wi <= wi + 1;
        wr_data_i <= wq[wi + 1];
    end
    always @(negedge clk_i) if (rd_valid_o === 1'b1) begin
        if (eq.size() == 0) chk("extra_byte", 8'h01, 8'h00);
        else chk("rd_data", rd_data_o, eq.pop_front());
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        int r;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        run(NFHP_OP_STATUS, 0, 0, 0, 1);
        run(NFHP_OP_PROGRAM, 0, 70000, 0, 8);
        run(NFHP_OP_READ, 0, 70000, 0, 8);
        run(NFHP_OP_READ, 1, 70000, 0, 4);
        run(NFHP_OP_READ, 2, 70000, 3, 4);
        for (int i = 0; i < 4; i++) begin
            r = {$random(seed)} % 131072;
            run(NFHP_OP_PROGRAM, 0, r, 100, 1 + {$random(seed)} % 8);
            run(NFHP_OP_READ, 0, r, 98, 12);
        end
        run(NFHP_OP_ERASE, 0, 70001, 0, 1);
        run(NFHP_OP_READ, 0, 70000, 0, 8);
        write_guard_en_i <= 1'b0;
        req_op_i <= NFHP_OP_ERASE;
        req_valid_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        chk("req_ready", {7'h0, req_ready_o}, 8'h00);
        chk("guard_block", {7'h0, guard_block_o}, 8'h01);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        @(posedge clk_i);
        run(NFHP_OP_STATUS, 0, 0, 0, 1);
        write_guard_en_i <= 1'b1;
        run(NFHP_OP_RESET, 0, 0, 0, 1);
        run(NFHP_OP_STATUS, 0, 0, 0, 1);
        give_verdict();
    end
endmodule
